// ---- cmsl_chip_config.sv ----
// Purpose: Chip mode capture, flash visibility, security, low power entry
// Assumes: Core reset chipRst_n asserted while straps are valid
// Notes: Straps and wake pin pass the three-flop pin synchroniser
// Function
// R1 - Latch three mode straps into mode status at reset release
// R2 - Latch flash-visibility strap into flash-visible bit at reset release
// R3 - Flash-visible bit one maps internal flash, zero hides it
// R4 - Mode status shows current mode; only limited software changes
// R5 - Code 000: special single chip, flash visible, debug active at once
// R6 - Other modes: debug allowed, active only after host activation command
// R7 - Codes 001/011: emulation narrow/wide, flash visible is inverted strap
// R8 - Code 010: special test wide, flash forced hidden
// R9 - Code 100: normal single chip, flash forced visible
// R10 - Codes 101/111: normal narrow/wide, flash visible equals strap
// R11 - Board must never strap 110; that mode forces flash visible
// R12 - Oscillator strap: one Colpitts, zero Pierce or external clock
// R13 - Secured state comes from flash security bits, persists over resets
// R14 - Secured normal single chip: all as unsecured but debug blocked
// R15 - Secured reset into expanded: flash disabled, debug blocked
// R16 - Unsecure by erase, reset to special single chip, erase verify
// R17 - Any reset before reprogramming returns device to secured
// R18 - Backdoor key access can also unsecure
// R19 - Full stop halts clocks and oscillator; wake by reset or irq
// R20 - Pseudo stop keeps oscillator, timer, watchdog; others off; code leaves clocksOn on in pseudo stop
// R21 - Wait halts cpu, buses static, peripherals run
// R22 - Straps sampled during reset; captured values hold afterwards
`timescale 1ns/10ps
`default_nettype none
module cmsl_chip_config
    import cmsl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chipRst_n,
    input wire logic mode_strap_c,
    input wire logic mode_strap_b,
    input wire logic mode_strap_a,
    input wire logic flash_visibility_strap,
    input wire logic oscillator_type_strap,
    input wire logic flashSecureBits,
    input wire logic eraseVerifyOk,
    input wire logic backdoorKeyOk,
    input wire logic debugActivateCmd,
    input wire logic modeWrite,
    input wire logic [2:0] modeWriteData,
    input wire logic stopInstr,
    input wire logic pseudoStopEn,
    input wire logic wait_instruction,
    input wire logic extIrq,
    output cmsl_cfg_t chipCfg,
    output logic [2:0] modeStatus,
    output logic flash_visible_bit,
    output logic flashMapped,
    output logic colpittsSel,
    output logic securedState,
    output logic eraseVerifyRun,
    output logic background_debugActive,
    output logic background_debugBlocked,
    output logic clocksOn,
    output logic oscOn,
    output logic periodic_interruptClkOn,
    output logic watchdog_submoduleClkOn,
    output logic periphClkOn,
    output logic cpuHalted,
    output cmsl_pwr_t pwrState
);
    // ==========================================================
    // Pin synchronisation
    cmsl_strap_t strapSync;
    logic irqSync;
    logic inReset;
    logic [2:0] mode_q;
    logic flashVis_q;
    logic osc_q;
    logic secured_q;
    logic verify_q;
    logic dbgAct_q;
    logic chipRstSync_n;
    logic chipRstPrev_q;
    logic [2:0] capMode_q;
    logic capVis_q;
    logic capOsc_q;
    logic modeOk;
    logic expanded;
    cmsl_pwr_t pwr_q;
    logic [6:0] syncOut;

    cmsl_strap_sync #(.W(7)) uSync
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .asyncIn({mode_strap_c, mode_strap_b, mode_strap_a,
                  flash_visibility_strap, oscillator_type_strap,
                  extIrq, chipRst_n}),
        .syncOut(syncOut)
    );

    // Unpack synchronised pins
    assign strapSync = cmsl_strap_t'(syncOut[6:2]);
    assign irqSync = syncOut[1];
    assign chipRstSync_n = syncOut[0];
    assign inReset = ~chipRstSync_n;

    // ==========================================================
    // Continuous strap sampling during reset
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capMode_q <= MODE_RESET;
            capVis_q <= FLASH_VIS_RESET;
            capOsc_q <= 1'b0;
        end
        else if (inReset)
        begin
            capMode_q <= strapSync.modeCode; // R22
            capVis_q <= strapSync.flashVisStrap; // R22
            capOsc_q <= strapSync.oscStrap; // R22
        end
    end

    // Reset release edge detect
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            chipRstPrev_q <= 1'b0;
        else
            chipRstPrev_q <= chipRstSync_n;
    end

    // Limited switching: special modes may move, normal modes may not
    assign modeOk = modeWrite && (mode_q[2] == 1'b0)
        && (modeWriteData != MODE_PERIPHERAL); // R4

    // ==========================================================
    // Mode and flash-visible bit
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= MODE_RESET;
            flashVis_q <= FLASH_VIS_RESET;
            osc_q <= 1'b0;
        end
        else if (chipRstSync_n && !chipRstPrev_q)
        begin
            mode_q <= capMode_q; // R1
            flashVis_q <= flash_vis_map(capMode_q, capVis_q); // R2 R5 R7 R8 R9 R10 R11
            osc_q <= capOsc_q; // R12
        end
        else if (chipRstSync_n && modeOk)
            mode_q <= modeWriteData; // R4 R22
    end

    // ==========================================================
    // Security state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            secured_q <= SECURED_RESET;
            verify_q <= 1'b0;
        end
        else if (inReset)
        begin
            secured_q <= flashSecureBits; // R13 R17
            verify_q <= 1'b0;
        end
        else if (chipRstSync_n && !chipRstPrev_q)
            verify_q <= secured_q && (capMode_q == MODE_SPECIAL_SINGLE); // R16
        else if (backdoorKeyOk)
            secured_q <= 1'b0; // R18
        else if (verify_q && eraseVerifyOk)
        begin
            secured_q <= 1'b0; // R16
            verify_q <= 1'b0;
        end
    end

    // ==========================================================
    // Background debug activation
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            dbgAct_q <= 1'b0;
        else if (inReset)
            dbgAct_q <= 1'b0;
        else if (chipRstSync_n && !chipRstPrev_q)
            dbgAct_q <= (capMode_q == MODE_SPECIAL_SINGLE); // R5
        else if (debugActivateCmd)
            dbgAct_q <= 1'b1; // R6
    end

    // ==========================================================
    // Low power state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pwr_q <= PWR_RUN;
        else if (inReset)
            pwr_q <= PWR_RUN; // R19
        else
        begin
            unique case (pwr_q)
                PWR_RUN:
                begin
                    if (stopInstr)
                        pwr_q <= pseudoStopEn ? PWR_PSTOP : PWR_STOP;
                    else if (wait_instruction)
                        pwr_q <= PWR_WAIT; // R21
                end
                PWR_WAIT, PWR_PSTOP, PWR_STOP:
                begin
                    if (irqSync)
                        pwr_q <= PWR_RUN; // R19 R20
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs
    assign expanded = is_expanded(mode_q);
    assign modeStatus = mode_q;
    assign flash_visible_bit = flashVis_q;
    assign flashMapped = flashVis_q && !(secured_q && expanded); // R3 R15
    assign colpittsSel = osc_q; // R12
    assign securedState = secured_q;
    assign eraseVerifyRun = verify_q;
    assign background_debugBlocked = secured_q && !verify_q; // R14 R15
    assign background_debugActive = dbgAct_q && !background_debugBlocked;
    assign chipCfg = '{modeCode: mode_q, flashVisibleBit: flashVis_q,
                       expandedMode: expanded, specialMode: ~mode_q[2]};
    assign pwrState = pwr_q;
    assign clocksOn = (pwr_q != PWR_STOP); // R19
    assign oscOn = (pwr_q != PWR_STOP); // R19 R20
    assign periodic_interruptClkOn = (pwr_q != PWR_STOP); // R20
    assign watchdog_submoduleClkOn = (pwr_q != PWR_STOP); // R20
    assign periphClkOn = (pwr_q == PWR_RUN) || (pwr_q == PWR_WAIT); // R20 R21
    assign cpuHalted = (pwr_q != PWR_RUN); // R21
endmodule
`default_nettype wire

// ---- cmsl_pkg.sv ----
// Purpose: Shared constants and types for chip mode, security, low power
// Assumes: Single system clock, straps sampled during reset
// Notes: Mode codes follow the strap order c,b,a
package cmsl_pkg;

    // ==========================================================
    // Mode codes
    localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
    localparam logic [2:0] MODE_EMUL_NARROW = 3'h1;
    localparam logic [2:0] MODE_SPECIAL_TEST = 3'h2;
    localparam logic [2:0] MODE_EMUL_WIDE = 3'h3;
    localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
    localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
    localparam logic [2:0] MODE_PERIPHERAL = 3'h6;
    localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;

    // ==========================================================
    // Reset values and widths
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic FLASH_VIS_RESET = 1'b1;
    localparam logic SECURED_RESET = 1'b1;
    localparam int SYNC_STAGES = 3;

    // ==========================================================
    // Power states
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_WAIT,
        PWR_PSTOP,
        PWR_STOP
    } cmsl_pwr_t;

    // Captured straps
    typedef struct packed {
        logic [2:0] modeCode;
        logic flashVisStrap;
        logic oscStrap;
    } cmsl_strap_t;

    // Decoded configuration
    typedef struct packed {
        logic [2:0] modeCode;
        logic flashVisibleBit;
        logic expandedMode;
        logic specialMode;
    } cmsl_cfg_t;

    // Flash-visible bit for a mode and strap
    function automatic logic flash_vis_map(input logic [2:0] m,
                                           input logic s);
        logic v;
        v = 1'b1;
        unique case (m)
            MODE_SPECIAL_SINGLE: v = 1'b1;
            MODE_EMUL_NARROW, MODE_EMUL_WIDE: v = ~s;
            MODE_SPECIAL_TEST: v = 1'b0;
            MODE_NORMAL_SINGLE: v = 1'b1;
            MODE_NORMAL_NARROW, MODE_NORMAL_WIDE: v = s;
            MODE_PERIPHERAL: v = 1'b1;
        endcase
        return v;
    endfunction

    // Expanded bus in this mode
    function automatic logic is_expanded(input logic [2:0] m);
        return (m != MODE_SPECIAL_SINGLE) && (m != MODE_NORMAL_SINGLE)
            && (m != MODE_PERIPHERAL);
    endfunction

endpackage

// ---- cmsl_strap_sync.sv ----
// Purpose: Three-stage synchroniser for strap and wake pins
// Assumes: Inputs asynchronous to clk_sys
// Notes: Output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module cmsl_strap_sync
#(
    parameter int W = 5
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // ==========================================================
    // Shift chain
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= asyncIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept per bit once stages agree
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            syncOut <= '0;
        else
            syncOut <= (s2_q & s3_q) | (syncOut & (s2_q | s3_q));
    end
endmodule
`default_nettype wire

// ---- cmsl_board_model.sv ----
// Purpose: Board strap resistors seen by the chip configuration block
// Assumes: Straps are static levels, held by the board while powered
// Notes: Peripheral code is never strapped; a request for it gets 000
`timescale 1ns/10ps
`default_nettype none
module cmsl_board_model
(
    input wire logic [2:0] wantCode,
    input wire logic wantVis,
    input wire logic wantOsc,
    output logic mode_strap_c,
    output logic mode_strap_b,
    output logic mode_strap_a,
    output logic flash_visibility_strap,
    output logic oscillator_type_strap
);
    // ==========================================================
    // Strap levels; peripheral code replaced to avoid bus conflicts
    logic [2:0] code;
    assign code = (wantCode == 3'h6) ? 3'h0 : wantCode;
    assign {mode_strap_c, mode_strap_b, mode_strap_a} = code;
    assign flash_visibility_strap = wantVis;
    assign oscillator_type_strap = wantOsc;
endmodule
`default_nettype wire

// ---- cmsl_chip_config_monitor.sv ----
// Purpose: Port-level checker for chip configuration
// Assumes: After settling, mode changes only by a software write
// Notes: Bound into every chip configuration instance
`timescale 1ns/10ps
`default_nettype none
module cmsl_chip_config_monitor
    import cmsl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chipRst_n,
    input wire logic stopInstr,
    input wire logic pseudoStopEn,
    input wire logic extIrq,
    input wire logic modeWrite,
    input wire cmsl_cfg_t chipCfg,
    input wire logic [2:0] modeStatus,
    input wire logic flash_visible_bit,
    input wire logic flashMapped,
    input wire logic securedState,
    input wire logic eraseVerifyRun,
    input wire logic background_debugBlocked,
    input wire logic clocksOn,
    input wire logic oscOn,
    input wire logic periphClkOn,
    input wire logic cpuHalted,
    input wire cmsl_pwr_t pwrState
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Named steps
    sequence fullStopReq;
        stopInstr && !pseudoStopEn && pwrState == PWR_RUN;
    endsequence
    sequence settledRun;
        chipRst_n [*8];
    endsequence
    // ==========================================================
    // Assertions
    flash_map_a: assert property (flashMapped |-> flash_visible_bit)
        else $error("flash mapped while hidden");
    test_hidden_a: assert property (modeStatus == MODE_SPECIAL_TEST
        && chipRst_n |-> !flash_visible_bit) else $error("test mode vis");
    single_vis_a: assert property (modeStatus == MODE_NORMAL_SINGLE
        && chipRst_n |-> flash_visible_bit) else $error("single hidden");
    stop_entry_a: assert property (fullStopReq |=> pwrState == PWR_STOP)
        else $error("stop not entered");
    stop_halt_a: assert property (pwrState == PWR_STOP |-> !clocksOn
        && !oscOn) else $error("clocks run in stop");
    stop_wake_a: assert property (pwrState == PWR_STOP && extIrq
        |-> ##[1:8] pwrState == PWR_RUN) else $error("no wake");
    pstop_osc_a: assert property (pwrState == PWR_PSTOP |-> oscOn
        && !periphClkOn) else $error("pseudo stop clocks");
    wait_cpu_a: assert property (pwrState == PWR_WAIT |-> cpuHalted
        && periphClkOn) else $error("wait state wrong");
    secured_exp_a: assert property (securedState && chipCfg.expandedMode
        |-> !flashMapped && background_debugBlocked)
        else $error("secured expanded leak");
    secured_dbg_a: assert property (securedState && !eraseVerifyRun
        |-> background_debugBlocked) else $error("debug not blocked");
    mode_hold_a: assert property (settledRun |-> $stable(modeStatus)
        || $past(modeWrite)) else $error("mode changed");
endmodule
bind cmsl_chip_config cmsl_chip_config_monitor u_cmsl_chip_config_monitor (
    .clk_sys, .rst_n, .chipRst_n, .stopInstr, .pseudoStopEn, .extIrq,
    .modeWrite,
    .chipCfg, .modeStatus, .flash_visible_bit, .flashMapped, .securedState,
    .eraseVerifyRun, .background_debugBlocked, .clocksOn, .oscOn,
    .periphClkOn, .cpuHalted, .pwrState);
`default_nettype wire

// ---- test_cmsl_chip_config.sv ----
// Purpose: Self-checking bench for chip mode, security and low power
// Assumes: Board model supplies straps
// Notes: Boot task pulses chip reset and waits for capture
`timescale 1ns/10ps
`default_nettype none
module test_cmsl_chip_config;
    import cmsl_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, chipRst_n = 1'b0;
    logic [2:0] wantCode = 3'h0, modeWriteData = 3'h0, modeStatus;
    logic wantVis = 1'b0, wantOsc = 1'b0, flashSecureBits = 1'b0;
    logic eraseVerifyOk = 1'b0, backdoorKeyOk = 1'b0, debugActivateCmd = 1'b0;
    logic modeWrite = 1'b0, stopInstr = 1'b0, pseudoStopEn = 1'b0;
    logic wait_instruction = 1'b0, extIrq = 1'b0;
    logic sc, sb, sa, sv, so, fvb, fm, cs, sec, dAct;
    logic evr, tickOn, dogOn;
    cmsl_cfg_t cfg;
    cmsl_pwr_t pwrState;
    int errCount = 0, checks = 0;
    cmsl_chip_config u_cmsl_chip_config (.clk_sys, .rst_n, .chipRst_n,
        .mode_strap_c(sc), .mode_strap_b(sb), .mode_strap_a(sa),
        .flash_visibility_strap(sv), .oscillator_type_strap(so),
        .flashSecureBits, .eraseVerifyOk, .backdoorKeyOk, .debugActivateCmd,
        .modeWrite, .modeWriteData, .stopInstr, .pseudoStopEn,
        .wait_instruction, .extIrq, .chipCfg(cfg), .modeStatus,
        .flash_visible_bit(fvb), .flashMapped(fm), .colpittsSel(cs),
        .securedState(sec), .eraseVerifyRun(evr),
        .background_debugActive(dAct),
        .background_debugBlocked(), .clocksOn(), .oscOn(),
        .periodic_interruptClkOn(tickOn), .watchdog_submoduleClkOn(dogOn),
        .periphClkOn(), .cpuHalted(), .pwrState);
    cmsl_board_model u_cmsl_board_model (.wantCode, .wantVis, .wantOsc,
        .mode_strap_c(sc), .mode_strap_b(sb), .mode_strap_a(sa),
        .flash_visibility_strap(sv), .oscillator_type_strap(so));
    // ==========================================================
    // Clock, compare and closing
    initial forever #10 clk_sys = ~clk_sys;
    task automatic chk(string nm, logic [2:0] seen, logic [2:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Expected flash visibility for a mode and strap
    function automatic logic expVis(logic [2:0] m, logic s);
        case (m)
            3'h2: return 1'b0;
            3'h1, 3'h3: return ~s;
            3'h5, 3'h7: return s;
            default: return 1'b1;
        endcase
    endfunction
    // ==========================================================
    // Scenarios
    task automatic boot(logic [2:0] m, logic v, logic o);
        chipRst_n <= 1'b0;
        wantCode <= m;
        wantVis <= v;
        wantOsc <= o;
        repeat (6) @(posedge clk_sys);
        chipRst_n <= 1'b1;
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic all_modes();
        for (int i = 0; i < 16; i++)
        begin
            if (i / 2 == 6)
                continue;
            boot(3'(i / 2), i[0], ~i[0]);
            chk("mode", modeStatus, 3'(i / 2));
            chk("flashVis", fvb, expVis(3'(i / 2), i[0]));
            chk("mapped", fm, expVis(3'(i / 2), i[0]));
            chk("colpitts", cs, !i[0]);
            chk("special", cfg.specialMode, i / 2 < 4);
            chk("dbgActive", dAct, i / 2 == 0);
            chk("dbgIdle", dAct, i / 2 == 0);
        end
    endtask
    task automatic debug_and_write();
        boot(3'h5, 1'b1, 1'b0);
        debugActivateCmd <= 1'b1;
        modeWrite <= 1'b1;
        modeWriteData <= 3'h1;
        @(posedge clk_sys);
        debugActivateCmd <= 1'b0;
        modeWrite <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("dbgOn", dAct, 1'b1);
        chk("modeKept", modeStatus, 3'h5);
        // Special mode: peripheral code refused, emulation code taken
        boot(3'h0, 1'b0, 1'b0);
        modeWrite <= 1'b1;
        modeWriteData <= 3'h6;
        @(posedge clk_sys);
        modeWriteData <= 3'h1;
        @(posedge clk_sys);
        chk("periphRefused", modeStatus, 3'h0);
        modeWrite <= 1'b0;
        @(posedge clk_sys);
        chk("modeWritten", modeStatus, 3'h1);
    endtask
    task automatic security();
        flashSecureBits <= 1'b1;
        boot(3'h4, 1'b0, 1'b0);
        chk("secured", sec, 1'b1);
        chk("singleMap", fm, 1'b1);
        debugActivateCmd <= 1'b1;
        @(posedge clk_sys);
        debugActivateCmd <= 1'b0;
        @(posedge clk_sys);
        chk("dbgBlocked", dAct, 1'b0);
        boot(3'h7, 1'b1, 1'b0);
        chk("expHidden", fm, 1'b0);
        backdoorKeyOk <= 1'b1;
        @(posedge clk_sys);
        backdoorKeyOk <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("backdoor", sec, 1'b0);
        boot(3'h0, 1'b0, 1'b0);
        chk("resecured", sec, 1'b1);
        chk("verifyRun", evr, 1'b1);
        eraseVerifyOk <= 1'b1;
        @(posedge clk_sys);
        eraseVerifyOk <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("erased", sec, 1'b0);
        flashSecureBits <= 1'b0;
        boot(3'h0, 1'b0, 1'b0);
    endtask
    task automatic low_power(logic ps, logic useWait, cmsl_pwr_t exp);
        pseudoStopEn <= ps;
        stopInstr <= ~useWait;
        wait_instruction <= useWait;
        @(posedge clk_sys);
        stopInstr <= 1'b0;
        wait_instruction <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("pwr", pwrState, exp);
        chk("tickClk", tickOn, exp != PWR_STOP);
        chk("dogClk", dogOn, exp != PWR_STOP);
        extIrq <= 1'b1;
        repeat (10) @(posedge clk_sys);
        extIrq <= 1'b0;
        chk("woken", pwrState, PWR_RUN);
        // Let the synchronised wake level drop before the next entry
        repeat (6) @(posedge clk_sys);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        all_modes();
        debug_and_write();
        security();
        low_power(1'b0, 1'b0, PWR_STOP);
        low_power(1'b1, 1'b0, PWR_PSTOP);
        low_power(1'b0, 1'b1, PWR_WAIT);
        wrap_up();
    end
    initial
    begin
        #400_000;
        errCount++;
        wrap_up();
    end
endmodule
`default_nettype wire
